//--- common/csf_pkg.sv
// constants for the conversion status and error flag register bank
// assumes a serial management port that presents decoded word accesses
package csf_pkg;
  localparam int CSF_AW = 8;
  localparam int CSF_DW = 16;
  localparam int CSF_CHW = 2;
  localparam int CSF_MAX_CH = 4;
  // register offsets
  localparam logic [7:0] CSF_ADDR_STATUS = 8'h18;
  localparam logic [7:0] CSF_ADDR_ERRCFG = 8'h19;
  // status field positions
  localparam int CSF_ST_CHAN_LO = 14;
  localparam int CSF_ST_WD = 11;
  localparam int CSF_ST_AHW = 10;
  localparam int CSF_ST_ALW = 9;
  localparam int CSF_ST_RDY = 6;
  localparam int CSF_ST_PEND_HI = 3;
  // error configuration field positions
  localparam int CSF_CF_WD_OUT = 13;
  localparam int CSF_CF_AH_OUT = 12;
  localparam int CSF_CF_AL_OUT = 11;
  localparam int CSF_CF_WD_IRQ = 5;
  localparam int CSF_CF_RDY_IRQ = 0;
  // reset values and writable mask
  localparam logic [15:0] CSF_STATUS_RST = 16'h0000;
  localparam logic [15:0] CSF_ERRCFG_RST = 16'h0000;
  localparam logic [15:0] CSF_ERRCFG_MASK = 16'h3821;
  localparam logic [15:0] CSF_RDATA_NONE = 16'h0000;
endpackage : csf_pkg

//--- verilog/csf_event_latch.sv
// one sticky event flag with a set input and a clear input
// assumes set and clear are single-cycle strobes in the mclk_i domain
`timescale 1ns/1ps
module csf_event_latch (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_o <= 1'b0;
    end
    else if (set_i)
    begin
      flag_o <= 1'b1;
    end
    else if (clr_i)
    begin
      flag_o <= 1'b0;
    end
  end
endmodule : csf_event_latch

//--- verilog/csf_status_bank.sv
// status and error configuration registers of the capacitance converter
// assumes decoded register strobes from the serial port and event pulses from the conversion core
`timescale 1ns/1ps
module csf_status_bank #(
  parameter int NUM_CH = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic result_rd_i,
  input wire logic [1:0] result_rd_chan_i,
  input wire logic wd_evt_i,
  input wire logic amp_high_evt_i,
  input wire logic amp_low_evt_i,
  input wire logic [1:0] evt_chan_i,
  input wire logic [3:0] conv_done_i,
  input wire logic ready_evt_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_out_n_o,
  output logic [3:0] result_wd_err_o,
  output logic [3:0] result_amp_warn_o
);
  localparam logic [2:0] NCH = 3'(NUM_CH);

  logic [15:0] err_cfg_r;
  logic [1:0] fault_source_channel_r;
  logic watchdog_timeout_flag;
  logic amp_high_warning_flag;
  logic amp_low_warning_flag;
  logic conversion_ready_flag;
  logic [3:0] chan_pending_result;
  logic [15:0] status_word;
  logic status_rd;
  logic cfg_wr;
  logic evt_chan_ok;
  logic rd_chan_ok;
  logic wd_set;
  logic ahw_set;
  logic alw_set;
  logic rdy_set;
  logic fault_chan_rd;
  logic irq_nxt;

  assign status_rd = reg_rd_i && (reg_addr_i == csf_pkg::CSF_ADDR_STATUS);
  assign cfg_wr = reg_wr_i && (reg_addr_i == csf_pkg::CSF_ADDR_ERRCFG);
  // channels missing in the two-channel build are ignored
  assign evt_chan_ok = ({1'b0, evt_chan_i} < NCH);
  assign rd_chan_ok = ({1'b0, result_rd_chan_i} < NCH);

  assign wd_set = wd_evt_i && evt_chan_ok && err_cfg_r[csf_pkg::CSF_CF_WD_IRQ];
  assign ahw_set = amp_high_evt_i && evt_chan_ok;
  assign alw_set = amp_low_evt_i && evt_chan_ok;
  assign rdy_set = ready_evt_i && err_cfg_r[csf_pkg::CSF_CF_RDY_IRQ];
  // reading the fault channel's result also releases the latched error
  assign fault_chan_rd = result_rd_i && (result_rd_chan_i == fault_source_channel_r);

  // only defined enable bits hold state; reserved ones read zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_cfg_r <= csf_pkg::CSF_ERRCFG_RST;
    end
    else if (cfg_wr)
    begin
      err_cfg_r <= reg_wdata_i & csf_pkg::CSF_ERRCFG_MASK;
    end
  end

  // latest error source wins; cleared with the flags so stale codes do not linger
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fault_source_channel_r <= 2'h0;
    end
    else if (wd_set || ahw_set || alw_set)
    begin
      fault_source_channel_r <= evt_chan_i;
    end
    else if (status_rd || fault_chan_rd)
    begin
      fault_source_channel_r <= 2'h0;
    end
  end

  csf_event_latch u_wd (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(wd_set),
    .clr_i(status_rd || fault_chan_rd),
    .flag_o(watchdog_timeout_flag)
  );

  csf_event_latch u_ahw (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(ahw_set),
    .clr_i(status_rd || fault_chan_rd),
    .flag_o(amp_high_warning_flag)
  );

  csf_event_latch u_alw (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(alw_set),
    .clr_i(status_rd || fault_chan_rd),
    .flag_o(amp_low_warning_flag)
  );

  csf_event_latch u_rdy (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .set_i(rdy_set),
    .clr_i(status_rd),
    .flag_o(conversion_ready_flag)
  );

  // per-channel pending flags and result-register error mirrors
  for (genvar c = 0; c < 4; c++)
  begin : g_chan
    logic present;
    logic chan_rd;
    logic evt_here;
    assign present = (c < NUM_CH);
    assign chan_rd = result_rd_i && rd_chan_ok && (result_rd_chan_i == 2'(c));
    assign evt_here = evt_chan_ok && (evt_chan_i == 2'(c));

    csf_event_latch u_pend (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .set_i(present && conv_done_i[c]),
      .clr_i(chan_rd),
      .flag_o(chan_pending_result[c])
    );

    csf_event_latch u_wd_out (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .set_i(present && evt_here && wd_evt_i && err_cfg_r[csf_pkg::CSF_CF_WD_OUT]),
      .clr_i(chan_rd),
      .flag_o(result_wd_err_o[c])
    );

    csf_event_latch u_aw_out (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .set_i(present && evt_here && ((amp_high_evt_i && err_cfg_r[csf_pkg::CSF_CF_AH_OUT]) ||
             (amp_low_evt_i && err_cfg_r[csf_pkg::CSF_CF_AL_OUT]))),
      .clr_i(chan_rd),
      .flag_o(result_amp_warn_o[c])
    );
  end

  // channel 0 sits in the highest pending bit
  always_comb
  begin
    status_word = csf_pkg::CSF_STATUS_RST;
    status_word[csf_pkg::CSF_ST_CHAN_LO +: 2] = fault_source_channel_r;
    status_word[csf_pkg::CSF_ST_WD] = watchdog_timeout_flag;
    status_word[csf_pkg::CSF_ST_AHW] = amp_high_warning_flag;
    status_word[csf_pkg::CSF_ST_ALW] = amp_low_warning_flag;
    status_word[csf_pkg::CSF_ST_RDY] = conversion_ready_flag;
    for (int c = 0; c < 4; c++)
    begin
      status_word[csf_pkg::CSF_ST_PEND_HI - c] = chan_pending_result[c];
    end
  end

  // read data captured on the strobe edge, before the clear lands
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= csf_pkg::CSF_RDATA_NONE;
    end
    else if (reg_rd_i)
    begin
      if (reg_addr_i == csf_pkg::CSF_ADDR_STATUS)
      begin
        reg_rdata_o <= status_word;
      end
      else if (reg_addr_i == csf_pkg::CSF_ADDR_ERRCFG)
      begin
        reg_rdata_o <= err_cfg_r;
      end
      else
      begin
        reg_rdata_o <= csf_pkg::CSF_RDATA_NONE;
      end
    end
  end

  // pin stays low while an enabled flag is standing
  assign irq_nxt = !((watchdog_timeout_flag && err_cfg_r[csf_pkg::CSF_CF_WD_IRQ]) ||
                     (conversion_ready_flag && err_cfg_r[csf_pkg::CSF_CF_RDY_IRQ]));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_out_n_o <= 1'b1;
    end
    else
    begin
      irq_out_n_o <= irq_nxt;
    end
  end

  property p_chan_field;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ahw_set && !wd_set) |=> (fault_source_channel_r == $past(evt_chan_i));
  endproperty
  a_chan_field: assert property (p_chan_field) else $error("fault channel not captured");

  property p_error_held;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (watchdog_timeout_flag && !status_rd && !fault_chan_rd) |=> watchdog_timeout_flag;
  endproperty
  a_error_held: assert property (p_error_held) else $error("watchdog flag dropped early");

  property p_wd_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wd_evt_i && evt_chan_ok && err_cfg_r[csf_pkg::CSF_CF_WD_IRQ]) |=> watchdog_timeout_flag ##1 !irq_out_n_o;
  endproperty
  a_wd_set: assert property (p_wd_set) else $error("timeout not flagged or pin idle");

  property p_amp_high;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (amp_high_evt_i && evt_chan_ok) |=> amp_high_warning_flag;
  endproperty
  a_amp_high: assert property (p_amp_high) else $error("amplitude high not flagged");

  property p_amp_low;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (amp_low_evt_i && evt_chan_ok) |=> amp_low_warning_flag;
  endproperty
  a_amp_low: assert property (p_amp_low) else $error("amplitude low not flagged");

  property p_read_clears;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (status_rd && !wd_evt_i && !ready_evt_i) |=> !watchdog_timeout_flag && !conversion_ready_flag
      && (reg_rdata_o[csf_pkg::CSF_ST_WD] == $past(watchdog_timeout_flag));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_reserved_zero;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $past(status_rd) |-> (reg_rdata_o[13:12] == 2'h0) && (reg_rdata_o[8:7] == 2'h0) && (reg_rdata_o[5:4] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

  property p_pending;
    @(posedge mclk_i) disable iff (!rst_n_i)
    conv_done_i[0] |=> chan_pending_result[0];
  endproperty
  a_pending: assert property (p_pending) else $error("channel 0 pending not set");

  property p_ready_irq;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ready_evt_i && err_cfg_r[csf_pkg::CSF_CF_RDY_IRQ]) |=> conversion_ready_flag ##1 !irq_out_n_o;
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("data ready not signalled");

  property p_wd_mirror;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wd_evt_i && evt_chan_ok && err_cfg_r[csf_pkg::CSF_CF_WD_OUT])
      |=> |(result_wd_err_o & (4'h1 << $past(evt_chan_i)));
  endproperty
  a_wd_mirror: assert property (p_wd_mirror) else $error("watchdog not mirrored");
endmodule : csf_status_bank

//--- dv/csf_host_model.sv
// host model: serial port master for the status bank
// assumes the bench calls its tasks; strobes move on falling edges
`timescale 1ns/1ps
module csf_host_model (
  input wire logic mclk_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_rd_o,
  output logic result_rd_o,
  output logic [1:0] result_rd_chan_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o = 1'b0;
    result_rd_o = 1'b0;
    result_rd_chan_o = 2'h0;
  end
  task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge mclk_i);
    q = reg_rdata_i;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines flip so stale values never pass for live ones
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : access
  task automatic collect(input logic [15:0] st);
    for (int c = 0; c < 4; c++)
    begin
      if (st[3 - c] === 1'b1)
      begin
        @(negedge mclk_i);
        result_rd_o = 1'b1;
        result_rd_chan_o = 2'(c);
        @(negedge mclk_i);
        result_rd_o = 1'b0;
        result_rd_chan_o = ~result_rd_chan_o;
      end
    end
  endtask : collect
endmodule : csf_host_model

//--- dv/test_csf_status_bank.sv
// bench for the status bank with a host model on the register side
// assumes four-channel build; events driven straight from the bench
`timescale 1ns/1ps
module test_csf_status_bank;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic res_rd;
  logic [1:0] res_ch;
  logic [2:0] err = 3'b000;
  logic [1:0] evt_ch = 2'h0;
  logic [3:0] done = 4'h0;
  logic rdy = 1'b0;
  logic [15:0] rdata;
  logic irq_n;
  logic [3:0] wd_mir;
  logic [3:0] amp_mir;
  logic [15:0] q;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 mclk_i = ~mclk_i;
  csf_host_model host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .result_rd_o(res_rd), .result_rd_chan_o(res_ch));
  csf_status_bank #(.NUM_CH(4)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .result_rd_i(res_rd),
    .result_rd_chan_i(res_ch), .wd_evt_i(err[2]), .amp_high_evt_i(err[1]), .amp_low_evt_i(err[0]),
    .evt_chan_i(evt_ch), .conv_done_i(done), .ready_evt_i(rdy), .reg_rdata_o(rdata),
    .irq_out_n_o(irq_n), .result_wd_err_o(wd_mir), .result_amp_warn_o(amp_mir));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_mir(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mir
  task automatic rdr(input logic [7:0] a);
    host.access(a, 1'b0, 16'h0000, q);
  endtask : rdr
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    host.access(a, 1'b1, d, q);
  endtask : wrr
  task automatic pulse(input logic [2:0] e, input logic [1:0] ch, input logic [3:0] dn, input logic r);
    @(negedge mclk_i);
    err = e;
    evt_ch = ch;
    done = dn;
    rdy = r;
    @(negedge mclk_i);
    err = 3'b000;
    evt_ch = ~ch;
    done = 4'h0;
    rdy = 1'b0;
  endtask : pulse
  task automatic t_config;
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h0000);
    wrr(csf_pkg::CSF_ADDR_ERRCFG, 16'hFFFF);
    rdr(csf_pkg::CSF_ADDR_ERRCFG);
    chk(q, 16'h3821);
    wrr(csf_pkg::CSF_ADDR_STATUS, 16'hFFFF);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h0000);
    rdr(8'h1A);
    chk(q, 16'h0000);
    $display("config test done");
  endtask : t_config
  task automatic t_watchdog;
    wrr(csf_pkg::CSF_ADDR_ERRCFG, 16'h2020);
    pulse(3'b100, 2'h1, 4'h0, 1'b0);
    @(negedge mclk_i);
    chk_pin(irq_n, 1'b0);
    chk_mir(wd_mir, 4'h2);
    host.collect(16'h0008);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h4800);
    pulse(3'b100, 2'h1, 4'h0, 1'b0);
    host.collect(16'h0004);
    repeat (2) @(negedge mclk_i);
    chk_pin(irq_n, 1'b1);
    chk_mir(wd_mir, 4'h0);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h0000);
    $display("watchdog test done");
  endtask : t_watchdog
  task automatic t_amp;
    wrr(csf_pkg::CSF_ADDR_ERRCFG, 16'h1800);
    pulse(3'b010, 2'h3, 4'h0, 1'b0);
    pulse(3'b001, 2'h2, 4'h0, 1'b0);
    @(negedge mclk_i);
    chk_mir(amp_mir, 4'hC);
    chk_pin(irq_n, 1'b1);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h8600);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h0000);
    $display("amplitude test done");
  endtask : t_amp
  task automatic t_ready;
    wrr(csf_pkg::CSF_ADDR_ERRCFG, 16'h0001);
    pulse(3'b000, 2'h0, 4'hF, 1'b1);
    @(negedge mclk_i);
    chk_pin(irq_n, 1'b0);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h004F);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h000F);
    host.collect(q);
    rdr(csf_pkg::CSF_ADDR_STATUS);
    chk(q, 16'h0000);
    chk_pin(irq_n, 1'b1);
    $display("ready test done");
  endtask : t_ready
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // generous ceiling: the whole sequence takes well under a hundred cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_config();
    t_watchdog();
    t_amp();
    t_ready();
    complete_run();
  end
endmodule : test_csf_status_bank
